// file: pkg/fft64_defines.svh
// register map, field positions, reset values and counts of the fft core
// assumes a 32-bit apb slave with a 12-bit byte address
`ifndef FFT64_DEFINES_SVH
`define FFT64_DEFINES_SVH

// register byte offsets
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_BANKS 12'h008
// 64-word windows: input samples and natural-order results
`define WIN_INPUT 4'h1
`define WIN_OUTPUT 4'h2

// control fields
`define CTRL_START 0
`define CTRL_DIR 1
`define CTRL_SCALE 2
`define CTRL_ENABLE 3
`define CTRL_CORE_RESET 4
`define CTRL_CFG_LO 5
`define CTRL_CFG_HI 6
`define CTRL_RESET_VALUE 32'h0000_0008

// memory configuration codes
`define CFG_SINGLE 2'h0
`define CFG_DUAL 2'h1
`define CFG_TRIPLE 2'h2

// transform geometry
`define LAST_BFLY 4'hf
`define LAST_STAGE 2'h2
`define LAST_K 2'h3
`define LAST_STEP 9'h17f
`define BASE_SHIFT 5'h02
`define EXTRA_SHIFT 5'h03
`define TW_QUARTER 5'h10

`endif

// file: pkg/fft64_pkg.sv
// types shared by the fft core and its surroundings
// assumes nothing beyond a systemverilog compiler
package fft64_pkg;

   // sequencer states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RD = 3'b010,
      ST_WR = 3'b100
   } eng_state_e;

   // one complex sample, imaginary in the upper half of a bus word
   typedef struct packed {
      logic signed [15:0] im;
      logic signed [15:0] re;
   } cplx_s;

   // state shown to user logic
   typedef struct packed {
      logic busy;
      logic result_valid;
      logic overflow_flag;
   } status_s;

endpackage

// file: hw/fft64_radix4_core.sv
// 64-point radix-4 in-place fft/ifft engine with an apb register port
// assumes apb master on pclk; user logic loads and reads samples over apb
// Operation
// - forward or inverse dft of 64 points
// - 64 results, 16-bit real and imaginary
// - radix-4 dif, 3 ranks of 16 butterflies
// - butterfly results written back to same addresses
// - twiddles generated inside, 16-bit precision
// - divide butterfly results by 4 each pass
// - extra halving on first pass when selected
// - overall scale 1/64 or 1/128
// - extra scale works both directions
// - inverse uses positive exponents, built-in 1/N
// - all registers update on rising clock
// - advance only while enable is high
// - direction 1 forward, 0 inverse
// - capture direction when start asserted
// - dual/triple recapture direction on resample strobe
// - core drives all memory controls itself
// - natural order in and out
// - single, dual and triple memory configurations
// - overlap load, transform and unload
// - capture extra scale at start and resample
// - overflow flag, cleared by reset/start/new result
`timescale 1ns/1ps
`include "fft64_defines.svh"

module fft64_radix4_core (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output fft64_pkg::status_s status
);
   import fft64_pkg::*;

   // quarter-wave cosine, q15
   function automatic logic [15:0] cos_q(input logic [4:0] i);
      case (i)
         5'h00: cos_q = 16'h7fff;
         5'h01: cos_q = 16'h7f61;
         5'h02: cos_q = 16'h7d89;
         5'h03: cos_q = 16'h7a7c;
         5'h04: cos_q = 16'h7641;
         5'h05: cos_q = 16'h70e2;
         5'h06: cos_q = 16'h6a6d;
         5'h07: cos_q = 16'h62f2;
         5'h08: cos_q = 16'h5a82;
         5'h09: cos_q = 16'h5133;
         5'h0a: cos_q = 16'h471d;
         5'h0b: cos_q = 16'h3c57;
         5'h0c: cos_q = 16'h30fc;
         5'h0d: cos_q = 16'h2528;
         5'h0e: cos_q = 16'h18f9;
         5'h0f: cos_q = 16'h0c8c;
         default: cos_q = 16'h0000;
      endcase
   endfunction

   // full-circle cosine of 2*pi*e/64, folded from the quarter table
   function automatic logic signed [15:0] tw_cos(input logic [5:0] e);
      logic [4:0] i;
      logic [4:0] j;
      i = {1'b0, e[3:0]};
      j = `TW_QUARTER - i;
      case (e[5:4])
         2'h0: tw_cos = signed'(cos_q(i));
         2'h1: tw_cos = -signed'(cos_q(j));
         2'h2: tw_cos = -signed'(cos_q(i));
         default: tw_cos = signed'(cos_q(j));
      endcase
   endfunction

   // in-place operand address of leg k of butterfly b in a rank
   function automatic logic [5:0] bfly_addr(input logic [1:0] st, input logic [3:0] b,
                                            input logic [1:0] k);
      case (st)
         2'h0: bfly_addr = {k, b};
         2'h1: bfly_addr = {b[3:2], k, b[1:0]};
         default: bfly_addr = {b, k};
      endcase
   endfunction

   // twiddle exponent applied to leg k after the butterfly
   function automatic logic [5:0] tw_exp(input logic [1:0] st, input logic [3:0] b,
                                         input logic [1:0] k);
      case (st)
         2'h0: tw_exp = 6'(k * b);
         2'h1: tw_exp = {{2'h0, k} * {2'h0, b[1:0]}, 2'h0};
         default: tw_exp = 6'h00;
      endcase
   endfunction

   // base-4 digit reversal: dif leaves results in this order
   function automatic logic [5:0] digit_rev(input logic [5:0] n);
      digit_rev = {n[1:0], n[3:2], n[5:4]};
   endfunction

   // next bank for a configuration
   function automatic logic [1:0] bank_next(input logic [1:0] cfg, input logic [1:0] b);
      case (cfg)
         `CFG_DUAL: bank_next = {1'b0, ~b[0]};
         `CFG_TRIPLE: bank_next = (b == 2'h2) ? 2'h0 : 2'(b + 2'h1);
         default: bank_next = 2'h0;
      endcase
   endfunction

   cplx_s mem [0:191];
   cplx_s buf_reg [0:3];
   eng_state_e state_reg;
   logic [31:0] ctrl_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [1:0] stage_reg;
   logic [3:0] bfly_reg;
   logic [1:0] k_reg;
   logic dir_reg;
   logic scale_reg;
   logic pending_reg;
   logic calc_ovf_reg;
   logic overflow_reg;
   logic result_valid_reg;
   logic [1:0] in_bank_reg;
   logic [1:0] calc_bank_reg;
   logic [1:0] out_bank_reg;
   logic [8:0] step_reg;

   // apb decode
   wire logic access = psel & penable;
   wire logic commit = access & pready_reg;
   wire logic wr_commit = commit & pwrite;
   wire logic [3:0] win = paddr[11:8];
   wire logic [5:0] widx = paddr[7:2];
   wire logic hit_ctrl = (paddr == `OFS_CTRL);
   wire logic hit_stat = (paddr == `OFS_STATUS);
   wire logic hit_bank = (paddr == `OFS_BANKS);
   wire logic hit_in = (win == `WIN_INPUT) & (paddr[1:0] == 2'h0);
   wire logic hit_out = (win == `WIN_OUTPUT) & (paddr[1:0] == 2'h0);
   wire logic mapped = hit_ctrl | hit_stat | hit_bank | hit_in | hit_out;
   wire logic wr_ctrl = wr_commit & hit_ctrl;
   wire logic wr_in = wr_commit & hit_in;
   wire logic [1:0] cfg = ctrl_reg[`CTRL_CFG_HI:`CTRL_CFG_LO];

   // sequencer control terms
   wire logic enable = ctrl_reg[`CTRL_ENABLE];
   wire logic soft_rst = wr_ctrl & pwdata[`CTRL_CORE_RESET];
   wire logic start_req = wr_ctrl & pwdata[`CTRL_START];
   wire logic idle = (state_reg == ST_IDLE);
   wire logic launch = start_req & idle & enable & ~soft_rst;
   wire logic last_leg = (k_reg == `LAST_K);
   wire logic finish = (state_reg == ST_WR) & enable & last_leg
                       & (bfly_reg == `LAST_BFLY) & (stage_reg == `LAST_STAGE);
   wire logic resample = finish & (pending_reg | start_req) & (cfg != `CFG_SINGLE);
   wire logic [5:0] eng_addr = bfly_addr(stage_reg, bfly_reg, k_reg);
   wire logic [7:0] eng_loc = {calc_bank_reg, eng_addr};
   wire logic [7:0] out_loc = {out_bank_reg, digit_rev(widx)};

   // butterfly leg k, scaling and twiddle for the current write cycle
   logic signed [17:0] sum_re;
   logic signed [17:0] sum_im;
   logic signed [17:0] sh_re;
   logic signed [17:0] sh_im;
   logic signed [15:0] tc;
   logic signed [15:0] ts;
   logic signed [32:0] pr_re;
   logic signed [32:0] pr_im;
   logic [5:0] te;
   logic rot;
   logic sat_ovf;
   cplx_s bf_out;
   always_comb begin
      sum_re = 18'sh0;
      sum_im = 18'sh0;
      rot = (k_reg == 2'h1) ^ dir_reg;
      case (k_reg)
         2'h0: begin
            sum_re = buf_reg[0].re + buf_reg[1].re + buf_reg[2].re + buf_reg[3].re;
            sum_im = buf_reg[0].im + buf_reg[1].im + buf_reg[2].im + buf_reg[3].im;
         end
         2'h2: begin
            sum_re = buf_reg[0].re - buf_reg[1].re + buf_reg[2].re - buf_reg[3].re;
            sum_im = buf_reg[0].im - buf_reg[1].im + buf_reg[2].im - buf_reg[3].im;
         end
         default: begin
            if (!rot) begin
               sum_re = buf_reg[0].re + buf_reg[1].im - buf_reg[2].re - buf_reg[3].im;
               sum_im = buf_reg[0].im - buf_reg[1].re - buf_reg[2].im + buf_reg[3].re;
            end else begin
               sum_re = buf_reg[0].re - buf_reg[1].im - buf_reg[2].re + buf_reg[3].im;
               sum_im = buf_reg[0].im + buf_reg[1].re - buf_reg[2].im - buf_reg[3].re;
            end
         end
      endcase
      // divide by 4, by 8 on the first rank with extra scale
      if ((stage_reg == 2'h0) && scale_reg) begin
         sh_re = sum_re >>> `EXTRA_SHIFT;
         sh_im = sum_im >>> `EXTRA_SHIFT;
      end else begin
         sh_re = sum_re >>> `BASE_SHIFT;
         sh_im = sum_im >>> `BASE_SHIFT;
      end
      te = tw_exp(stage_reg, bfly_reg, k_reg);
      tc = tw_cos(te);
      ts = dir_reg ? -tw_cos(6'(te - 6'h10)) : tw_cos(6'(te - 6'h10));
      // part-selects are unsigned, so the sign is put back before the multiply
      pr_re = signed'(sh_re[15:0]) * tc - signed'(sh_im[15:0]) * ts;
      pr_im = signed'(sh_re[15:0]) * ts + signed'(sh_im[15:0]) * tc;
      sat_ovf = 1'b0;
      bf_out.re = sh_re[15:0];
      bf_out.im = sh_im[15:0];
      // unity twiddle bypassed so rank 3 and leg 0 stay exact
      if (te != 6'h00) begin
         bf_out.re = pr_re[30:15];
         bf_out.im = pr_im[30:15];
         if (pr_re[32:30] != {3{pr_re[30]}}) begin
            sat_ovf = 1'b1;
            bf_out.re = pr_re[32] ? 16'sh8000 : 16'sh7fff;
         end
         if (pr_im[32:30] != {3{pr_im[30]}}) begin
            sat_ovf = 1'b1;
            bf_out.im = pr_im[32] ? 16'sh8000 : 16'sh7fff;
         end
      end
   end

   // sample memory: engine port and apb port; arrays carry no reset
   always_ff @(posedge pclk) begin
      if ((state_reg == ST_WR) && enable) begin
         mem[eng_loc] <= bf_out;
      end
      if (wr_in) begin
         mem[{in_bank_reg, widx}] <= pwdata;
      end
   end

   // operand fetch into the butterfly buffer
   always_ff @(posedge pclk) begin
      if ((state_reg == ST_RD) && enable) begin
         buf_reg[k_reg] <= mem[eng_loc];
      end
   end

   // apb answer: one wait state, registered outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= access & ~pready_reg;
         pslverr_reg <= access & ~pready_reg & ~mapped;
         if (access & ~pready_reg) begin
            prdata_reg <= hit_ctrl ? ctrl_reg :
                          hit_stat ? {28'h0, pending_reg, result_valid_reg, overflow_reg,
                                      ~idle} :
                          hit_bank ? {26'h0, out_bank_reg, calc_bank_reg, in_bank_reg} :
                          hit_out ? mem[out_loc] : 32'h0000_0000;
         end
      end
   end

   // control register; start and core reset read back as zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `CTRL_RESET_VALUE;
      end else if (wr_ctrl) begin
         ctrl_reg <= {25'h0, pwdata[6:5], 1'b0, pwdata[3:1], 1'b0};
      end
   end

   // sequencer: ranks, butterflies and legs, banks and captures
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         stage_reg <= 2'h0;
         bfly_reg <= 4'h0;
         k_reg <= 2'h0;
         dir_reg <= 1'b1;
         scale_reg <= 1'b0;
         pending_reg <= 1'b0;
         calc_ovf_reg <= 1'b0;
         overflow_reg <= 1'b0;
         result_valid_reg <= 1'b0;
         in_bank_reg <= 2'h0;
         calc_bank_reg <= 2'h0;
         out_bank_reg <= 2'h0;
         step_reg <= 9'h000;
      end else if (soft_rst) begin
         state_reg <= ST_IDLE;
         k_reg <= 2'h0;
         pending_reg <= 1'b0;
         calc_ovf_reg <= 1'b0;
         overflow_reg <= 1'b0;
         result_valid_reg <= 1'b0;
         in_bank_reg <= 2'h0;
         calc_bank_reg <= 2'h0;
         out_bank_reg <= 2'h0;
      end else if (launch || resample) begin
         // a start while busy queues one more transform in dual/triple only
         state_reg <= ST_RD;
         stage_reg <= 2'h0;
         bfly_reg <= 4'h0;
         k_reg <= 2'h0;
         step_reg <= 9'h000;
         dir_reg <= ctrl_reg[`CTRL_DIR];
         scale_reg <= ctrl_reg[`CTRL_SCALE];
         pending_reg <= 1'b0;
         calc_ovf_reg <= 1'b0;
         calc_bank_reg <= in_bank_reg;
         in_bank_reg <= bank_next(cfg, in_bank_reg);
         if (launch) begin
            overflow_reg <= 1'b0;
         end else begin
            overflow_reg <= calc_ovf_reg | sat_ovf;
            out_bank_reg <= calc_bank_reg;
            result_valid_reg <= 1'b1;
         end
      end else begin
         if (start_req && !idle && (cfg != `CFG_SINGLE)) begin
            pending_reg <= 1'b1;
         end
         if (enable && !idle) begin
            step_reg <= 9'(step_reg + 9'h001);
            k_reg <= 2'(k_reg + 2'h1);
            case (state_reg)
               ST_RD: begin
                  if (last_leg) begin
                     state_reg <= ST_WR;
                  end
               end
               ST_WR: begin
                  if (sat_ovf) begin
                     calc_ovf_reg <= 1'b1;
                  end
                  if (last_leg) begin
                     state_reg <= ST_RD;
                     bfly_reg <= 4'(bfly_reg + 4'h1);
                     if (bfly_reg == `LAST_BFLY) begin
                        stage_reg <= 2'(stage_reg + 2'h1);
                     end
                     if (finish) begin
                        state_reg <= ST_IDLE;
                        // new result vector replaces the old overflow state
                        overflow_reg <= calc_ovf_reg | sat_ovf;
                        out_bank_reg <= calc_bank_reg;
                        result_valid_reg <= 1'b1;
                     end
                  end
               end
               default: state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign status = '{busy: ~idle, result_valid: result_valid_reg, overflow_flag: overflow_reg};

   // checks
   property p_start_capture;
      @(posedge pclk) disable iff (!presetn)
      launch |=> (dir_reg == $past(ctrl_reg[`CTRL_DIR])) && (state_reg == ST_RD)
                 && (stage_reg == 2'h0) && !overflow_reg;
   endproperty
   a_start_capture: assert property (p_start_capture)
      else $error("start did not capture direction or begin rank one");

   property p_resample;
      @(posedge pclk) disable iff (!presetn)
      resample && !soft_rst |=> (scale_reg == $past(ctrl_reg[`CTRL_SCALE]))
                               && (out_bank_reg == $past(calc_bank_reg)) && result_valid_reg;
   endproperty
   a_resample: assert property (p_resample)
      else $error("back to back transform did not resample settings");

   property p_pass_length;
      @(posedge pclk) disable iff (!presetn)
      finish |-> (step_reg == `LAST_STEP);
   endproperty
   a_pass_length: assert property (p_pass_length)
      else $error("transform did not take 3 ranks of 16 butterflies");

   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      !enable && !wr_ctrl |=> $stable(state_reg) && $stable(k_reg) && $stable(bfly_reg);
   endproperty
   a_hold: assert property (p_hold)
      else $error("sequencer moved while disabled");

   property p_no_ovf_scaled;
      @(posedge pclk) disable iff (!presetn)
      (state_reg == ST_WR) && scale_reg |-> !sat_ovf;
   endproperty
   a_no_ovf_scaled: assert property (p_no_ovf_scaled)
      else $error("overflow with extra scaling selected");

   property p_read_to_write;
      @(posedge pclk) disable iff (!presetn)
      (state_reg == ST_RD) && last_leg && enable && !wr_ctrl ##1 (enable && !wr_ctrl) [*3]
         |=> (state_reg == ST_WR) && last_leg && ($past(k_reg, 3) == 2'h0)
             && (bfly_reg == $past(bfly_reg, 4));
   endproperty
   a_read_to_write: assert property (p_read_to_write)
      else $error("butterfly did not write back its four legs");

   property p_core_reset;
      @(posedge pclk) disable iff (!presetn)
      soft_rst |=> idle && !overflow_reg && !result_valid_reg;
   endproperty
   a_core_reset: assert property (p_core_reset)
      else $error("core reset did not return to idle");

   property p_single_no_queue;
      @(posedge pclk) disable iff (!presetn)
      (cfg == `CFG_SINGLE) |-> (in_bank_reg == 2'h0) && !resample;
   endproperty
   a_single_no_queue: assert property (p_single_no_queue)
      else $error("single configuration left bank zero");

endmodule

// file: bench/fft64_user_model.sv
// apb master standing in for the user logic that loads vectors and reads results
// assumes a slave on pclk that raises pready for one cycle per transfer
`timescale 1ns/1ps

module fft64_user_model (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // bus idle from time zero
   initial begin
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end

   // one transfer; a sample word is im high, re low, 16-bit two's complement each
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      // answer taken at the rising edge that samples pready high, then released
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      // released lines must not keep showing the last value
      paddr <= ~paddr;
      pwdata <= ~pwdata;
   endtask
endmodule

// file: bench/fft64_radix4_core_tb.sv
// self-checking bench of the fft core: random and corner vectors over apb
// assumes one wait state per apb transfer and busy shown on the status port
`timescale 1ns/1ps
`include "fft64_defines.svh"

module fft64_radix4_core_tb;
   import fft64_pkg::*;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   fft64_pkg::status_s status;
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   int busy_cycles = 0;
   logic [31:0] seed;
   logic [31:0] rd;
   logic err;
   cplx_s vec[64];
   real ref_re[64];
   real ref_im[64];

   fft64_radix4_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .status(status));

   fft64_user_model um (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   initial begin
      pclk = 1'h0;
      forever #4 pclk = ~pclk;
   end

   // ceiling cuts a hang short; busy cycles counted for the latency check
   always @(posedge pclk) begin
      cycles++;
      if (status.busy === 1'h1) busy_cycles++;
      if (cycles == 20000) begin
         fail_count++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("checks %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic verify(input logic ok, input string what);
      samples_checked++;
      if (ok !== 1'h1) begin
         fail_count++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask

   function automatic logic [31:0] next_rand();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [31:0] ctrl(input logic [1:0] cfg, input logic rst,
         input logic en, input logic scale, input logic dir, input logic st);
      return {25'h0, cfg, rst, en, scale, dir, st};
   endfunction

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      um.xfer(1'h1, a, d, rd, err);
   endtask

   task automatic rdreg(input logic [11:0] a);
      um.xfer(1'h0, a, 32'h0, rd, err);
   endtask

   // full range only with extra scale, so the unscaled runs cannot saturate
   task automatic load_vec(input logic full);
      logic [31:0] r;
      for (int n = 0; n < 64; n++) begin
         r = next_rand();
         vec[n].re = full ? r[15:0] : {{3{r[12]}}, r[12:0]};
         vec[n].im = full ? r[31:16] : {{3{r[28]}}, r[28:16]};
         wr(12'h100 + 12'(4 * n), vec[n]);
      end
   endtask

   // waits out busy, including a queued follow-on transform
   task automatic wait_done();
      int n;
      n = 0;
      repeat (2) @(negedge pclk);
      while (status.busy !== 1'h0 && n < 3000) begin
         @(negedge pclk);
         n++;
      end
      verify(status.busy === 1'h0, "transform did not end");
   endtask

   // float dft scaled 1/64 or 1/128; forward uses the negative exponent
   task automatic build_ref(input logic dir, input logic scale);
      real th;
      real sg;
      sg = dir ? -1.0 : 1.0;
      for (int k = 0; k < 64; k++) begin
         ref_re[k] = 0.0;
         ref_im[k] = 0.0;
         for (int n = 0; n < 64; n++) begin
            th = 6.283185307179586 * n * k / 64.0;
            ref_re[k] += vec[n].re * $cos(th) - sg * vec[n].im * $sin(th);
            ref_im[k] += vec[n].im * $cos(th) + sg * vec[n].re * $sin(th);
         end
         ref_re[k] /= scale ? 128.0 : 64.0;
         ref_im[k] /= scale ? 128.0 : 64.0;
      end
   endtask

   // truncation in three ranks and q15 twiddles leave a few lsb of error
   task automatic check_out(input logic dir, input logic scale, input string name);
      cplx_s got;
      real dr;
      real di;
      build_ref(dir, scale);
      for (int k = 0; k < 64; k++) begin
         rdreg(12'h200 + 12'(4 * k));
         got = rd;
         dr = got.re - ref_re[k];
         di = got.im - ref_im[k];
         verify((^got) !== 1'hx && dr < 6.0 && dr > -6.0 && di < 6.0 && di > -6.0, name);
      end
      $display("test %s finished", name);
   endtask

   task automatic run_single(input logic dir, input logic scale);
      int b0;
      load_vec(scale);
      wr(`OFS_CTRL, ctrl(2'h0, 1'h0, 1'h1, scale, dir, 1'h0));
      b0 = busy_cycles;
      wr(`OFS_CTRL, ctrl(2'h0, 1'h0, 1'h1, scale, dir, 1'h1));
      wait_done();
      verify(busy_cycles - b0 === 384, "busy length");
      verify(status === 3'h2, "status after transform");
      check_out(dir, scale, "single");
   endtask

   initial begin
      presetn = 1'h0;
      seed = 32'h0001_3dc6;
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      @(negedge pclk);
      verify(status === 3'h0, "status after reset");
      rdreg(`OFS_CTRL);
      verify(rd === `CTRL_RESET_VALUE, "control after reset");
      rdreg(12'h00c);
      verify(err === 1'h1 && rd === 32'h0, "unmapped read");
      $display("test reset finished");
      // corner: four operands push one leg-one twiddle product past full scale
      for (int n = 0; n < 64; n++) begin
         wr(12'h100 + 12'(4 * n), (n % 16 != 8) ? 32'h0 :
            {n[5] ? 16'h8001 : 16'h7fff, (n[4] ^ n[5]) ? 16'h8001 : 16'h7fff});
      end
      wr(`OFS_CTRL, ctrl(2'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0));
      wr(`OFS_CTRL, ctrl(2'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1));
      wait_done();
      verify(status === 3'h3, "overflow not flagged");
      rdreg(`OFS_STATUS);
      verify(rd === 32'h0000_0006, "status register");
      $display("test overflow finished");
      // every direction with and without the extra halving
      for (int i = 0; i < 4; i++) run_single(i[0], i[1]);
      // start while disabled is dropped
      wr(`OFS_CTRL, ctrl(2'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0));
      wr(`OFS_CTRL, ctrl(2'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1));
      repeat (4) @(negedge pclk);
      verify(status.busy === 1'h0, "start while disabled");
      // forward run frozen midway while direction and scale are flipped
      load_vec(1'h0);
      wr(`OFS_CTRL, ctrl(2'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0));
      wr(`OFS_CTRL, ctrl(2'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1));
      repeat (100) @(posedge pclk);
      wr(`OFS_CTRL, ctrl(2'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0));
      repeat (600) @(posedge pclk);
      verify(status.busy === 1'h1, "frozen while disabled");
      wr(`OFS_CTRL, ctrl(2'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0));
      wait_done();
      check_out(1'h1, 1'h0, "freeze");
      // core reset in mid-transform
      wr(`OFS_CTRL, ctrl(2'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1));
      repeat (50) @(posedge pclk);
      wr(`OFS_CTRL, ctrl(2'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0));
      @(negedge pclk);
      verify(status === 3'h0, "status after core reset");
      rdreg(`OFS_BANKS);
      verify(rd === 32'h0, "banks after core reset");
      $display("test core reset finished");
      // dual and triple: second vector loaded during the first, queued with new settings
      for (int c = 1; c < 3; c++) begin
         wr(`OFS_CTRL, ctrl(c[1:0], 1'h1, 1'h1, 1'h0, 1'h0, 1'h0));
         load_vec(1'h0);
         wr(`OFS_CTRL, ctrl(c[1:0], 1'h0, 1'h1, 1'h0, 1'h0, 1'h1));
         load_vec(1'h1);
         wr(`OFS_CTRL, ctrl(c[1:0], 1'h0, 1'h1, 1'h1, 1'h1, 1'h0));
         wr(`OFS_CTRL, ctrl(c[1:0], 1'h0, 1'h1, 1'h1, 1'h1, 1'h1));
         verify(status.busy === 1'h1, "load overlapped transform");
         repeat (2) wait_done();
         check_out(1'h1, 1'h1, c == 1 ? "dual" : "triple");
      end
      complete_run();
   end
endmodule
